// [common/isp_pkg.sv]
// Purpose : shared constants and carrier types for the serial download port
// Assumes : 100 MHz system clock, four-byte instruction frames
// Notes   : opcode values are the instruction bytes seen on the serial line

package isp_pkg;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  // one received byte, tagged with its slot inside the four-byte frame
  typedef struct packed {
    logic [1:0] slot;
    logic [7:0] data;
  } isp_byte_t;

  localparam int ISP_BYTE_W = $bits(isp_byte_t);

  // background sweep that runs while the part reports busy
  typedef enum logic {OP_PAGE, OP_ERASE} isp_sweep_t;

  // ----------------------------------------------------------------------
  // instruction bytes
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_GROUP_AC = 8'hAC;
  localparam logic [7:0] SUB_ENABLE   = 8'h53;
  localparam logic [7:0] SUB_ERASE    = 8'h80;
  localparam logic [7:0] SUB_WR_LOCK  = 8'hE0;
  localparam logic [7:0] SUB_WR_FUSE  = 8'hA0;
  localparam logic [7:0] SUB_WR_FUSEH = 8'hA8;
  localparam logic [7:0] SUB_WR_FUSEX = 8'hA4;
  localparam logic [7:0] CMD_POLL     = 8'hF0;
  localparam logic [7:0] CMD_LOAD_EXT = 8'h4D;
  localparam logic [7:0] CMD_LOAD_HI  = 8'h48;
  localparam logic [7:0] CMD_LOAD_LO  = 8'h40;
  localparam logic [7:0] CMD_WR_PAGE  = 8'h4C;
  localparam logic [7:0] CMD_WR_EE    = 8'hC0;
  localparam logic [7:0] CMD_RD_HI    = 8'h28;
  localparam logic [7:0] CMD_RD_LO    = 8'h20;
  localparam logic [7:0] CMD_RD_EE    = 8'hA0;
  localparam logic [7:0] CMD_RD_LOCK  = 8'h58;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h50;
  localparam logic [7:0] SUB_FUSE_HI  = 8'h08;
  localparam logic [7:0] CMD_RD_SIG   = 8'h30;
  localparam logic [7:0] CMD_RD_CAL   = 8'h38;

  // ----------------------------------------------------------------------
  // layout and values
  // ----------------------------------------------------------------------
  localparam int          PAGE_AW      = 7;       // word bits inside a page
  localparam int          FUSE_LOW     = 0;
  localparam int          FUSE_HIGH    = 1;
  localparam int          FUSE_EXT     = 2;
  localparam int          LOCK_IDX     = 3;
  localparam logic [7:0]  ERASED_BYTE  = 8'hFF;   // also unprogrammed fuse
  localparam logic [15:0] ERASED_WORD  = 16'hFFFF;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam real CLK_PERIOD_NS      = 10.0;
  localparam real PAGE_WRITE_WAIT_MS = 4.5;
  localparam real EEPROM_BYTE_WAIT_MS = 3.6;
  localparam real CHIP_ERASE_WAIT_MS = 9.0;
  localparam int  PAGE_WRITE_WAIT_CYC = $rtoi(PAGE_WRITE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  EEPROM_BYTE_WAIT_CYC = $rtoi(EEPROM_BYTE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  CHIP_ERASE_WAIT_CYC = $rtoi(CHIP_ERASE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam int  WAIT_W = 20;                    // holds the longest wait

endpackage

// [verilog/isp_byte_fifo.sv]
// Purpose : small valid/ready buffer between byte receiver and decoder
// Assumes : single clock, asynchronous active-high reset
// Notes   : full and empty are exact; a stalled reader really fills it
`timescale 1ns/10ps
`default_nettype none

module isp_byte_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // filling side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // draining side
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               rd;
    logic [PW-1:0]               wr;
    logic [CW-1:0]               cnt;
  } isp_fifo_st_t;

  isp_fifo_st_t q, d;
  logic         push;
  logic         pop;

  assign inReady  = (q.cnt != CW'(DEPTH));
  assign outValid = (q.cnt != '0);
  assign outData  = q.mem[q.rd];

  // ----------------------------------------------------------------------
  // pointer and count update
  // ----------------------------------------------------------------------
  always_comb begin
    d    = q;
    push = inValid && inReady;
    pop  = outValid && outReady;
    if (push) begin
      d.mem[q.wr] = inData;
      d.wr = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
    end
    d.cnt = q.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // isp_byte_fifo
`default_nettype wire

// [verilog/isp_download_port.sv]
// Purpose : serial download port, device end, for flash and eeprom
// Assumes : serial clock and data come from a programmer, asynchronous
// Notes   : Functional notes
// Functional notes
// R1 - link works only while reset pin low
// R2 - enable first; other instructions rejected before (reads and poll still answer before enable)
// R3 - programmer keeps clock phases above limit
// R4 - sample incoming bits on rising clock edge
// R5 - change outgoing bit on falling clock edge
// R6 - programmer powers up with reset, clock low (model powers up with reset pin high)
// R7 - programmer waits 20ms before enable (model waits WAKE_NS, 2000 ns)
// R8 - echo enable second byte during third byte
// R9 - programmer sends four bytes, retries via reset
// R10 - page buffer loaded per byte, seven-bit address
// R11 - programmer loads low byte before high
// R12 - write-page commits buffer, page from address
// R13 - extended address byte kept until reloaded
// R14 - programmer waits for write completion
// R15 - write, eeprom and erase wait times
// R16 - eeprom byte write self-erases location first
// R17 - chip erase sets both arrays to FF
// R18 - read returns stored content on output
// R19 - reset pin high ends session
// R20 - poll returns busy in bit zero
// R21 - fuse and lock read one unprogrammed
// R22 - bit stream framed in four-byte frames
`timescale 1ns/10ps
`default_nettype none

module isp_download_port
  import isp_pkg::*;
#(
  parameter int          FLASH_AW   = 17,                  // flash word address bits
  parameter int          EE_AW      = 12,                  // eeprom byte address bits
  parameter int          PAGE_WAIT  = PAGE_WRITE_WAIT_CYC,
  parameter int          EE_WAIT    = EEPROM_BYTE_WAIT_CYC,
  parameter int          ERASE_WAIT = CHIP_ERASE_WAIT_CYC,
  parameter logic [23:0] SIGNATURE  = 24'h12_3456,         // arbitrary value
  parameter logic [7:0]  CALIB_BYTE = 8'h80                // arbitrary value
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // programming pins
  input  wire logic resetPinN,
  input  wire logic serialClk,
  input  wire logic serial_prog_data_in,
  output logic      serial_prog_data_out,
  // status
  output logic      progSessionActive,
  output logic      progEnabled,
  output logic      operation_pending_flag
);
  typedef struct packed {
    logic [1:0]          rstSync;     // [0] is the first flop
    logic [1:0]          sckSync;
    logic [1:0]          sdiSync;
    logic                sckPrev;
    logic                active;
    logic [2:0]          rxBit;
    logic [7:0]          rxShift;
    logic [1:0]          rxSlot;
    logic                pushV;
    isp_byte_t           pushD;
    logic [7:0]          txShift;
    logic [7:0]          txNext;
    logic                txLoad;
    logic                sdo;
    logic [7:0]          b0, b1, b2, b3;
    logic                execPend;
    logic                enabled;
    logic [7:0]          extAddr;
    logic [FLASH_AW-1:0] pageBase;
    logic [WAIT_W-1:0]   waitCnt;
    logic                sweep;
    isp_sweep_t          sweepOp;
    logic [FLASH_AW-1:0] sweepIdx;
    logic [3:0][7:0]     fuse;
    logic                pend;
  } isp_st_t;

  isp_st_t         q, d;
  logic [15:0]     flashMem [2**FLASH_AW];
  logic [7:0]      eeMem    [2**EE_AW];
  logic [15:0]     pageBuf  [2**PAGE_AW];
  isp_byte_t       popD;
  logic            popV, popReady, inReady;
  logic            rise, fall, pop, doExec, pageWeLo, pageWeHi, eeWe;
  logic [23:0]     rdAddr;
  logic [15:0]     rdWord;

  // ----------------------------------------------------------------------
  // receive buffer
  // ----------------------------------------------------------------------
  // the decoder stalls one cycle per frame, so the buffer absorbs a byte
  isp_byte_fifo #(.WIDTH(ISP_BYTE_W), .DEPTH(2)) u_rxBuf (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .inData   (q.pushD),
    .inValid  (q.pushV),
    .inReady  (inReady),
    .outData  (popD),
    .outValid (popV),
    .outReady (popReady)
  );

  assign popReady = !q.execPend;
  assign pop      = popV && popReady;
  assign rise     = q.sckSync[1] && !q.sckPrev;
  assign fall     = !q.sckSync[1] && q.sckPrev;
  assign doExec   = q.execPend && q.active;
  assign rdAddr   = {q.extAddr, q.b1, popD.data};
  assign rdWord   = flashMem[rdAddr[FLASH_AW-1:0]];

  // ----------------------------------------------------------------------
  // link, framing, decode and busy sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    d        = q;
    pageWeLo = 1'b0;
    pageWeHi = 1'b0;
    eeWe     = 1'b0;
    // two flops before anything looks at the pins
    d.rstSync = {q.rstSync[0], resetPinN};
    d.sckSync = {q.sckSync[0], serialClk};
    d.sdiSync = {q.sdiSync[0], serial_prog_data_in};
    d.sckPrev = q.sckSync[1];
    d.active  = !q.rstSync[1];                                   // see R1
    if (q.pushV && inReady) begin
      d.pushV = 1'b0;
    end
    if (!q.active) begin
      // pin high: leave the session and restart framing           see R19
      d.rxBit    = '0;
      d.rxSlot   = '0;                                           // see R22
      d.txLoad   = 1'b0;
      d.txShift  = '0;
      d.sdo      = 1'b0;
      d.enabled  = 1'b0;
      d.execPend = 1'b0;
    end else begin
      if (rise) begin
        d.rxShift = {q.rxShift[6:0], q.sdiSync[1]};             // see R4
        d.rxBit   = q.rxBit + 3'd1;
        if (q.rxBit == 3'd7) begin
          d.pushV  = 1'b1;
          d.pushD  = '{slot: q.rxSlot, data: d.rxShift};
          d.rxSlot = q.rxSlot + 2'd1;                            // see R22
          d.txLoad = 1'b1;
        end
      end
      if (fall) begin
        // in a session output only moves here, msb first         see R5
        if (q.txLoad) begin
          d.sdo     = q.txNext[7];
          d.txShift = {q.txNext[6:0], 1'b0};
          d.txLoad  = 1'b0;
        end else begin
          d.sdo     = q.txShift[7];
          d.txShift = {q.txShift[6:0], 1'b0};
        end
      end
    end
    // frame assembly; the default answer echoes the byte just taken
    if (pop) begin
      d.txNext = popD.data;                                      // see R8
      case (popD.slot)
        2'd0: d.b0 = popD.data;
        2'd1: d.b1 = popD.data;
        2'd2: begin
          d.b2 = popD.data;
          case (q.b0)
            CMD_POLL:    d.txNext = {7'd0, q.pend};              // see R20
            CMD_RD_LO:   d.txNext = rdWord[7:0];                 // see R18
            CMD_RD_HI:   d.txNext = rdWord[15:8];                // see R18
            CMD_RD_EE:   d.txNext = eeMem[EE_AW'({q.b1[3:0], popD.data})];
            CMD_RD_LOCK: d.txNext = q.fuse[(q.b1 == SUB_FUSE_HI) ? FUSE_HIGH : LOCK_IDX];
            CMD_RD_FUSE: d.txNext = q.fuse[(q.b1 == SUB_FUSE_HI) ? FUSE_EXT : FUSE_LOW];
            CMD_RD_SIG:  d.txNext = SIGNATURE[8*popD.data[1:0] +: 8];
            CMD_RD_CAL:  d.txNext = CALIB_BYTE;
            default:     d.txNext = popD.data;
          endcase
        end
        default: begin
          d.b3       = popD.data;
          d.execPend = q.active;
        end
      endcase
    end
    // background sweep: page copy or full erase, one word a cycle
    if (q.waitCnt != '0) begin
      d.waitCnt = q.waitCnt - 1'b1;
    end
    if (q.sweep) begin
      d.sweepIdx = q.sweepIdx + 1'b1;
      if ((q.sweepOp == OP_PAGE && q.sweepIdx == FLASH_AW'(2**PAGE_AW - 1)) ||
          (q.sweepOp == OP_ERASE && q.sweepIdx == '1)) begin
        d.sweep = 1'b0;
      end
    end
    // execute a complete frame
    if (doExec) begin
      d.execPend = 1'b0;
      if (q.b0 == CMD_GROUP_AC && q.b1 == SUB_ENABLE) begin
        d.enabled = 1'b1;                                        // see R2
      end else if (q.enabled && !q.pend) begin                   // see R2
        // while busy the poll and the reads still answer; loads and writes are dropped
        case (q.b0)
          CMD_LOAD_EXT: d.extAddr = q.b2;                        // see R13
          CMD_LOAD_LO:  pageWeLo = 1'b1;                         // see R10
          CMD_LOAD_HI:  pageWeHi = 1'b1;                         // see R10
          CMD_WR_PAGE: begin
            d.pageBase = FLASH_AW'({q.extAddr, q.b1, q.b2[7:PAGE_AW], 7'd0}); // see R12
            d.sweep    = 1'b1;
            d.sweepOp  = OP_PAGE;
            d.sweepIdx = '0;
            d.waitCnt  = WAIT_W'(PAGE_WAIT);                     // see R15
          end
          CMD_WR_EE: begin
            eeWe      = 1'b1;                                    // see R16
            d.waitCnt = WAIT_W'(EE_WAIT);                        // see R15
          end
          CMD_GROUP_AC: begin
            d.waitCnt = WAIT_W'(PAGE_WAIT);
            case (q.b1)
              SUB_ERASE: begin
                d.sweep          = 1'b1;                         // see R17
                d.sweepOp        = OP_ERASE;
                d.sweepIdx       = '0;
                d.fuse[LOCK_IDX] = ERASED_BYTE;
                d.waitCnt        = WAIT_W'(ERASE_WAIT);          // see R15
              end
              // a lock bit once programmed only returns via erase or sys_rst
              SUB_WR_LOCK:  d.fuse[LOCK_IDX]  = q.fuse[LOCK_IDX] & q.b3; // see R21
              SUB_WR_FUSE:  d.fuse[FUSE_LOW]  = q.b3;
              SUB_WR_FUSEH: d.fuse[FUSE_HIGH] = q.b3;
              SUB_WR_FUSEX: d.fuse[FUSE_EXT]  = q.b3;
              default:      d.waitCnt = q.waitCnt;
            endcase
          end
          default: d.enabled = q.enabled;
        endcase
      end
    end
    d.pend = (d.waitCnt != '0) || d.sweep;
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q         <= '0;
      q.rstSync <= 2'b11;
      q.fuse    <= {4{ERASED_BYTE}};                              // see R21
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // arrays; no reset, contents are what software has written
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (pageWeLo) begin
      pageBuf[q.b2[PAGE_AW-1:0]][7:0] <= q.b3;
    end
    if (pageWeHi) begin
      pageBuf[q.b2[PAGE_AW-1:0]][15:8] <= q.b3;
    end
    if (q.sweep && q.sweepOp == OP_PAGE) begin
      flashMem[q.pageBase | q.sweepIdx] <= pageBuf[q.sweepIdx[PAGE_AW-1:0]]; // see R12
    end else if (q.sweep) begin
      flashMem[q.sweepIdx] <= ERASED_WORD;                       // see R17
    end
    // a byte write replaces the old value, which is the self-erase
    if (eeWe) begin
      eeMem[EE_AW'({q.b1[3:0], q.b2})] <= q.b3;                  // see R16
    end else if (q.sweep && q.sweepOp == OP_ERASE && int'(q.sweepIdx) < 2**EE_AW) begin
      // compared as int: a size cast of the array depth wraps to zero
      eeMem[q.sweepIdx[EE_AW-1:0]] <= ERASED_BYTE;               // see R17
    end
  end

  assign serial_prog_data_out   = q.sdo;
  assign progSessionActive      = q.active;
  assign progEnabled            = q.enabled;
  assign operation_pending_flag = q.pend;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  chk_rise_sample: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R4
    (q.active && rise) |=> q.rxShift[0] == $past(q.sdiSync[1]))
    else $error("input bit not taken on rising edge");
  chk_fall_shift: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R5
    !$stable(q.sdo) |-> ($past(fall) || !$past(q.active)))
    else $error("output changed away from falling edge");
  chk_enable_echo: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R8
    (pop && popD.slot == 2'd1 && popD.data == SUB_ENABLE) |=> q.txNext == SUB_ENABLE)
    else $error("enable echo not prepared");
  chk_reject_locked: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R2
    (doExec && !q.enabled && !q.sweep) |=> !q.sweep)
    else $error("operation started before enable");
  chk_session_exit: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R19
    !q.active |=> (!q.enabled && q.rxSlot == 2'd0 && !q.sdo))
    else $error("session state survived reset pin high");
  chk_erase_busy: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R17
    (doExec && q.enabled && !q.pend && q.b0 == CMD_GROUP_AC && q.b1 == SUB_ERASE)
    |=> (q.sweep && q.sweepOp == OP_ERASE && q.waitCnt == WAIT_W'(ERASE_WAIT) && q.pend))
    else $error("chip erase did not start its busy time");
  chk_poll_reply: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R20
    (pop && popD.slot == 2'd2 && q.b0 == CMD_POLL) |=> q.txNext == {7'd0, $past(q.pend)})
    else $error("poll answer does not carry busy");
  chk_ext_hold: assert property (@(posedge sys_clk) disable iff (sys_rst) // see R13
    !$stable(q.extAddr) |-> ($past(doExec) && $past(q.b0) == CMD_LOAD_EXT))
    else $error("extended address changed without load");

endmodule // isp_download_port
`default_nettype wire

// [verification/sidp_prog_model.sv]
// Purpose : programmer model driving the serial download link
// Assumes : link clock stands low between frames
// Notes   : power-up wait is scaled down to keep runs short
`timescale 1ns/10ps
`default_nettype none

module sidp_prog_model
  import isp_pkg::*;
#(
  parameter real HALF_NS  = 62.5,   // each phase far above 3 cycles
  parameter real PULSE_NS = 100.0,  // reset pin pulse width
  parameter real WAKE_NS  = 2000.0  // scaled power-up wait
) (
  // programming pins
  output logic      resetPinN,
  output logic      serialClk,
  output logic      serial_prog_data_in,
  input  wire logic serial_prog_data_out
);
  // ----------------------------------------
  // link control
  // ----------------------------------------
  // clock low from power-up; data idles on the inverse of its last bit
  initial begin
    resetPinN           = 1'b1;
    serialClk           = 1'b0;
    serial_prog_data_in = 1'b1;
  end

  // clock held low, then a reset pulse so framing starts clean
  task automatic start_session();
    serialClk = 1'b0;
    resetPinN = 1'b1;
    #(PULSE_NS) resetPinN = 1'b0;
    #(WAKE_NS);
  endtask

  task automatic end_session();
    resetPinN = 1'b1;
    #(PULSE_NS);
  endtask

  // one frame, msb first; reply bit taken as the clock rises
  task automatic frame(input logic [31:0] cmd, output logic [31:0] rsp);
    rsp = '0;
    for (int i = 31; i >= 0; i--) begin
      serial_prog_data_in = cmd[i];
      #(HALF_NS) serialClk = 1'b1;
      rsp[i] = serial_prog_data_out;
      #(HALF_NS) serialClk = 1'b0;
    end
    serial_prog_data_in = ~cmd[0];
  endtask

  // all four bytes always sent; a missing echo costs a reset pulse
  task automatic enable(output logic ok);
    logic [31:0] r;
    ok = 1'b0;
    for (int n = 0; n < 3 && !ok; n++) begin
      if (n > 0) start_session();
      frame({CMD_GROUP_AC, SUB_ENABLE, 16'h0000}, r);
      ok = (r[15:8] === SUB_ENABLE);
    end
  endtask

  // polling replaces blind waits, so no access lands mid-write
  task automatic wait_idle(output logic ok);
    logic [31:0] r;
    ok = 1'b0;
    for (int n = 0; n < 20 && !ok; n++) begin
      frame({CMD_POLL, 24'h00_0000}, r);
      ok = (r[0] === 1'b0);
    end
  endtask
endmodule // sidp_prog_model
`default_nettype wire

// [verification/serial_isp_download_port_bench.sv]
// Purpose : self-checking bench for the serial download port
// Assumes : busy times and flash size shortened by parameters
// Notes   : expectations follow the instruction rules only
`timescale 1ns/10ps
`default_nettype none

module serial_isp_download_port_bench
  import isp_pkg::*;
;
  // busy outlasts the reply slot of one poll frame, so a busy poll is seen
  localparam int          WAIT_CYC = 600;
  localparam int          LIMIT    = 60000;
  localparam logic [7:0]  CAL_VAL  = 8'h5A;       // arbitrary value
  localparam logic [23:0] SIG_VAL  = 24'h0A_1B2C; // arbitrary value
  logic sys_clk, sys_rst, resetPinN, serialClk, serial_prog_data_in;
  logic serial_prog_data_out, progSessionActive, progEnabled, operation_pending_flag;
  int   mismatches = 0;
  int   check_count = 0;
  int   cycleCount = 0;

  // ----------------------------------------
  // design and programmer
  // ----------------------------------------
  isp_download_port #(.FLASH_AW(8), .EE_AW(8), .PAGE_WAIT(WAIT_CYC), .EE_WAIT(WAIT_CYC),
    .ERASE_WAIT(WAIT_CYC), .SIGNATURE(SIG_VAL), .CALIB_BYTE(CAL_VAL)) isp_download_port_i (
    .sys_clk, .sys_rst, .resetPinN,
    .serialClk, .serial_prog_data_in, .serial_prog_data_out, .progSessionActive,
    .progEnabled, .operation_pending_flag);
  sidp_prog_model sidp_prog_model_i (.resetPinN, .serialClk, .serial_prog_data_in,
    .serial_prog_data_out);

  // clock and hang guard
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycleCount++;
    if (cycleCount == LIMIT) begin
      mismatches++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd(input logic [31:0] c, output logic [7:0] d);
    logic [31:0] r;
    sidp_prog_model_i.frame(c, r);
    d = r[7:0];
  endtask

  // a write must raise busy, then polling must see it fall
  task automatic settle();
    logic       ok;
    logic [7:0] d;
    repeat (20) @(posedge sys_clk);
    #1;
    check("busy", 8'h01, {7'h00, operation_pending_flag});
    rd({CMD_POLL, 24'h00_0000}, d);
    check("poll busy", 8'h01, d);
    sidp_prog_model_i.wait_idle(ok);
    check("ready", 8'h01, {7'h00, ok});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_enable();
    logic [31:0] r;
    sidp_prog_model_i.start_session();
    check("session", 8'h01, {7'h00, progSessionActive});
    sidp_prog_model_i.frame({CMD_GROUP_AC, SUB_ERASE, 16'h0000}, r);
    repeat (20) @(posedge sys_clk);
    check("early erase", 8'h00, {7'h00, operation_pending_flag});
    sidp_prog_model_i.frame({CMD_GROUP_AC, SUB_ENABLE, 16'h0000}, r);
    check("echo", SUB_ENABLE, r[15:8]);
    repeat (20) @(posedge sys_clk);
    check("enabled", 8'h01, {7'h00, progEnabled});
    $display("test enable done");
  endtask

  task automatic t_eeprom();
    logic [31:0] r;
    logic [7:0]  d;
    logic [7:0]  vals [2] = '{8'h3C, 8'hC3};
    logic [7:0]  fsub [3] = '{SUB_WR_FUSE, SUB_WR_FUSEH, SUB_WR_FUSEX};
    logic [7:0]  frd  [3] = '{CMD_RD_FUSE, CMD_RD_LOCK, CMD_RD_FUSE};
    logic [7:0]  fb1  [3] = '{8'h00, SUB_FUSE_HI, SUB_FUSE_HI};
    logic [7:0]  fval [3] = '{8'hE2, 8'hD9, 8'hFD};
    sidp_prog_model_i.frame({CMD_GROUP_AC, SUB_ERASE, 16'h0000}, r);
    settle();
    rd({CMD_RD_EE, 24'h00_0500}, d);
    check("erased eeprom", ERASED_BYTE, d);
    rd({CMD_RD_LO, 24'h00_9000}, d);
    check("erased flash", ERASED_BYTE, d);
    rd({CMD_RD_LOCK, 24'h00_0000}, d);
    check("lock", ERASED_BYTE, d);
    rd({CMD_RD_FUSE, 24'h00_0000}, d);
    check("fuse", ERASED_BYTE, d);
    sidp_prog_model_i.frame({CMD_GROUP_AC, SUB_WR_LOCK, 16'h00FC}, r);
    settle();
    rd({CMD_RD_LOCK, 24'h00_0000}, d);
    check("lock set", 8'hFC, d);
    // low, high and extended fuse each written, then read on its own path
    foreach (fsub[i]) begin
      sidp_prog_model_i.frame({CMD_GROUP_AC, fsub[i], 8'h00, fval[i]}, r);
      settle();
      rd({frd[i], fb1[i], 16'h0000}, d);
      check("fuse byte", fval[i], d);
    end
    // second value sets bits the first cleared: only a self-erase gets it
    foreach (vals[i]) begin
      sidp_prog_model_i.frame({CMD_WR_EE, 16'h0005, vals[i]}, r);
      settle();
      rd({CMD_RD_EE, 24'h00_0500}, d);
      check("eeprom byte", vals[i], d);
    end
    $display("test eeprom done");
  endtask

  // two pages, same word, low byte loaded first each time
  task automatic t_page();
    logic [31:0] r;
    logic [7:0]  d;
    logic [7:0]  lo [2] = '{8'h12, 8'h56};
    logic [7:0]  hi [2] = '{8'h34, 8'h78};
    logic [7:0]  pg [2] = '{8'h00, 8'h80};
    sidp_prog_model_i.frame({CMD_LOAD_EXT, 24'h00_0000}, r);
    for (int p = 0; p < 2; p++) begin
      sidp_prog_model_i.frame({CMD_LOAD_LO, 16'h0003, lo[p]}, r);
      sidp_prog_model_i.frame({CMD_LOAD_HI, 16'h0003, hi[p]}, r);
      sidp_prog_model_i.frame({CMD_WR_PAGE, 8'h00, pg[p], 8'h00}, r);
      settle();
    end
    for (int p = 0; p < 2; p++) begin
      rd({CMD_RD_LO, 8'h00, pg[p] | 8'h03, 8'h00}, d);
      check("flash low", lo[p], d);
      rd({CMD_RD_HI, 8'h00, pg[p] | 8'h03, 8'h00}, d);
      check("flash high", hi[p], d);
    end
    $display("test page done");
  endtask

  task automatic t_leave();
    logic       ok;
    logic [7:0] d;
    sidp_prog_model_i.end_session();
    check("session off", 8'h00, {7'h00, progSessionActive});
    check("enable off", 8'h00, {7'h00, progEnabled});
    sidp_prog_model_i.start_session();
    sidp_prog_model_i.enable(ok);
    check("re-enable", 8'h01, {7'h00, ok});
    rd({CMD_RD_EE, 24'h00_0500}, d);
    check("kept eeprom", 8'hC3, d);
    rd({CMD_RD_CAL, 24'h00_0000}, d);
    check("calibration", CAL_VAL, d);
    rd({CMD_RD_SIG, 16'h0001, 8'h00}, d);
    check("signature", SIG_VAL[15:8], d);
    $display("test leave done");
  endtask

  // ----------------------------------------
  // sequence and verdict
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    t_enable();
    t_eeprom();
    t_page();
    t_leave();
    wrap_up();
  end
endmodule // serial_isp_download_port_bench
`default_nettype wire
